// file: rtl/cfs_status_bank.sv
// Contract
// - a failed runtime register checksum sets control bit 4, which stays until the host writes one to it.
// - after a clear, the next checksum check that still fails sets the checksum flag again.
// - the checksum flag reads zero while its enable is off.
// - a short to supply on the interrupt pin sets control bit 3, with no enable.
// - writing one to the interrupt pin flag clears it only once the short is gone.
// - a thermal shutdown sets control bit 2, reads zero when disabled, and clears only once the fault ended.
// - a short on the tag pin sets control bit 1, reads zero when disabled, and clears only once removed.
// - a packet check failure sets control bit 0, sticky, cleared by writing one, set again on a failing transaction.
// - a corrected single error on configuration load sets test bit 3, gated by its enable, cleared by writing one.
// - a double error on configuration load sets test bit 2, with no enable, cleared by writing one.
// - a completed self-test run sets test bit 1 unless disabled, cleared by writing one.
// - a self-test run that finds a fault sets test bit 0 unless disabled, cleared by writing one.
// - a control flag never clears just because its fault went away; only a write of one, or turning off its enable (bits 4, 2, 1), clears it.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_defines.svh"
module cfs_status_bank
   import cfs_pkg::*;
#(
   parameter int DATA_W = `CFS_DATA_W
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire cfs_req_s req_i,
   input wire cfs_ctrl_ev_s ctrl_ev_i,
   input wire cfs_test_ev_s test_ev_i,
   input wire cfs_enable_s enable_i,
   input wire logic irq_pin_short_i,
   input wire logic tag_pin_short_i,
   output logic [DATA_W-1:0] rdata_o,
   output logic rvalid_o,
   output logic [DATA_W-1:0] control_fault_status_o,
   output logic [DATA_W-1:0] test_load_event_status_o,
   output logic interrupt_request_pin_o,
   output logic interrupt_request_pin_oe_o
);
   // ****************************************
   // elaboration checks
   // ****************************************
   // register map and field positions are fixed at eight bits
   if (DATA_W != 8) begin
      $error("cfs_status_bank supports only 8-bit registers");
   end
   // ****************************************
   // pin fault conditions from outside the clock domain
   // ****************************************
   wire logic [1:0] pin_short;
   cfs_sync3 #(
      .W(2)
   ) u_pin_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .en_i(ce_i),
      .d_i({irq_pin_short_i, tag_pin_short_i}),
      .q_o(pin_short)
   );
   wire logic irq_short_lvl;
   wire logic tag_short_lvl;
   assign irq_short_lvl = pin_short[1];
   assign tag_short_lvl = pin_short[0];
   // ****************************************
   // decode of host writes
   // ****************************************
   function automatic logic hit(input cfs_req_s r, input logic [7:0] a);
      hit = r.wr && (r.addr == a);
   endfunction
   wire logic wr_ctrl;
   wire logic wr_test;
   wire logic [7:0] ctrl_clr;
   wire logic [7:0] test_clr;
   assign wr_ctrl = hit(req_i, `CFS_ADDR_CTRL);
   assign wr_test = hit(req_i, `CFS_ADDR_TEST);
   // zero bits of the mask are ignored
   assign ctrl_clr = wr_ctrl ? req_i.wdata : 8'h00;
   assign test_clr = wr_test ? req_i.wdata : 8'h00;
   // ****************************************
   // control fault flags
   // ****************************************
   wire logic [7:0] ctrl_set;
   wire logic [7:0] ctrl_hold;
   wire logic [7:0] ctrl_gate;
   wire logic [7:0] ctrl_q;
   assign ctrl_set = {3'h0,
                      ctrl_ev_i.crc_fail,
                      irq_short_lvl,
                      ctrl_ev_i.overtemp,
                      tag_short_lvl,
                      ctrl_ev_i.pec_fail};
   // level faults block their own clear
   assign ctrl_hold = {3'h0, 1'b0, irq_short_lvl, ctrl_ev_i.overtemp, tag_short_lvl, 1'b0};
   // crc and pec are event flags: flag survives end of fault
   assign ctrl_gate = {3'h0,
                       enable_i.checksum_irq_enable,
                       1'b1,
                       enable_i.overtemperature_irq_enable,
                       enable_i.tag_pin_irq_enable,
                       1'b1};
   cfs_w1c_reg #(
      .W(8),
      .MASK(`CFS_CTRL_MASK)
   ) u_ctrl (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .en_i(ce_i),
      .set_i(ctrl_set),
      .clr_i(ctrl_clr),
      .hold_i(ctrl_hold),
      .gate_i(ctrl_gate),
      .q_o(ctrl_q)
   );
   // ****************************************
   // test and load event flags
   // ****************************************
   wire logic [7:0] test_set;
   wire logic [7:0] test_gate;
   wire logic [7:0] test_q;
   assign test_set = {4'h0,
                      test_ev_i.single_err,
                      test_ev_i.double_err,
                      test_ev_i.selftest_done,
                      test_ev_i.selftest_fault};
   assign test_gate = {4'h0,
                       enable_i.corrected_error_irq_enable,
                       1'b1,
                       enable_i.selftest_done_irq_enable,
                       enable_i.selftest_fault_irq_enable};
   cfs_w1c_reg #(
      .W(8),
      .MASK(`CFS_TEST_MASK)
   ) u_test (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .en_i(ce_i),
      .set_i(test_set),
      .clr_i(test_clr),
      .hold_i(8'h00),
      .gate_i(test_gate),
      .q_o(test_q)
   );
   // ****************************************
   // read port and interrupt output
   // ****************************************
   wire logic [7:0] nxt_rdata;
   wire logic nxt_irq;
   // unmapped addresses read zero
   assign nxt_rdata = (req_i.addr == `CFS_ADDR_CTRL) ? ctrl_q :
                      (req_i.addr == `CFS_ADDR_TEST) ? test_q : 8'h00;
   // flags are already zero when disabled, so any bit counts
   assign nxt_irq = (|ctrl_q) | (|test_q);
   logic [7:0] rdata_ff;
   logic rvalid_ff;
   logic irq_ff;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_ff <= `CFS_RST_VAL;
         rvalid_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else if (ce_i) begin
         rdata_ff <= req_i.rd ? nxt_rdata : rdata_ff;
         rvalid_ff <= req_i.rd;
         irq_ff <= nxt_irq;
      end
   end
   logic [7:0] ctrl_out_ff;
   logic [7:0] test_out_ff;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_out_ff <= `CFS_RST_VAL;
         test_out_ff <= `CFS_RST_VAL;
      end else if (ce_i) begin
         ctrl_out_ff <= ctrl_q;
         test_out_ff <= test_q;
      end
   end
   assign rdata_o = rdata_ff;
   assign rvalid_o = rvalid_ff;
   assign control_fault_status_o = ctrl_out_ff;
   assign test_load_event_status_o = test_out_ff;
   // open drain, active low: enable pulls the pin low
   assign interrupt_request_pin_o = 1'b0;
   assign interrupt_request_pin_oe_o = irq_ff;
endmodule
`default_nettype wire

// file: rtl/cfs_defines.svh
`ifndef CFS_DEFINES_SVH
`define CFS_DEFINES_SVH
// ****************************************
// register addresses
// ****************************************
`define CFS_ADDR_CTRL 8'h22
`define CFS_ADDR_TEST 8'h23
// ****************************************
// control status field positions
// ****************************************
`define CFS_CTRL_CRC 4
`define CFS_CTRL_IRQPIN 3
`define CFS_CTRL_TEMP 2
`define CFS_CTRL_TAG 1
`define CFS_CTRL_PEC 0
// ****************************************
// test status field positions
// ****************************************
`define CFS_TEST_SEC 3
`define CFS_TEST_DED 2
`define CFS_TEST_DONE 1
`define CFS_TEST_FAULT 0
// ****************************************
// reset values and implemented-bit masks
// ****************************************
`define CFS_RST_VAL 8'h00
`define CFS_CTRL_MASK 8'h1F
`define CFS_TEST_MASK 8'h0F
`define CFS_DATA_W 8
`endif

// file: rtl/cfs_pkg.sv
package cfs_pkg;
   // ****************************************
   // grouped carriers
   // ****************************************
   typedef struct packed {
      logic crc_fail;
      logic irq_pin_short;
      logic overtemp;
      logic tag_pin_short;
      logic pec_fail;
   } cfs_ctrl_ev_s;
   typedef struct packed {
      logic single_err;
      logic double_err;
      logic selftest_done;
      logic selftest_fault;
   } cfs_test_ev_s;
   typedef struct packed {
      logic checksum_irq_enable;
      logic overtemperature_irq_enable;
      logic tag_pin_irq_enable;
      logic corrected_error_irq_enable;
      logic selftest_done_irq_enable;
      logic selftest_fault_irq_enable;
   } cfs_enable_s;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cfs_req_s;
endpackage

// file: rtl/cfs_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_sync3 #(
   parameter int W = 2
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   // ****************************************
   // three-stage pin synchroniser
   // ****************************************
   if (W < 1) begin
      $error("cfs_sync3 width out of range");
   end
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;
   wire logic [W-1:0] agree;
   wire logic [W-1:0] nxt_q;
   // change only counts once stages two and three agree
   assign agree = ~(s2_ff ^ s3_ff);
   assign nxt_q = (agree & s3_ff) | (~agree & q_ff);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q_ff <= '0;
      end else if (en_i) begin
         s1_ff <= d_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff <= nxt_q;
      end
   end
   assign q_o = q_ff;
endmodule
`default_nettype wire

// file: rtl/cfs_w1c_reg.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_w1c_reg #(
   parameter int W = 8,
   parameter logic [7:0] MASK = 8'hFF
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   input wire logic [W-1:0] set_i,
   input wire logic [W-1:0] clr_i,
   input wire logic [W-1:0] hold_i,
   input wire logic [W-1:0] gate_i,
   output logic [W-1:0] q_o
);
   // ****************************************
   // sticky flags, write one to clear
   // ****************************************
   // refused at elaboration: the mask parameter only covers eight bits
   if (W < 1 || W > 8) begin
      $error("cfs_w1c_reg width out of range");
   end
   logic [W-1:0] flag_ff;
   wire logic [W-1:0] clr_ok;
   wire logic [W-1:0] nxt_flag;
   // clear refused while fault still present
   assign clr_ok = clr_i & ~hold_i;
   // set wins over a clear in the same cycle; disabled bits read zero
   assign nxt_flag = ((flag_ff & ~clr_ok) | set_i) & gate_i & MASK[W-1:0];
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_ff <= '0;
      end else if (en_i) begin
         flag_ff <= nxt_flag;
      end
   end
   assign q_o = flag_ff;
endmodule
`default_nettype wire

// file: testbench/cfs_status_bank_props.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_status_bank_props
   import cfs_pkg::*;
#(
   parameter int DATA_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire cfs_req_s req_i,
   input wire cfs_ctrl_ev_s ctrl_ev_i,
   input wire cfs_test_ev_s test_ev_i,
   input wire cfs_enable_s enable_i,
   input wire logic irq_pin_short_i,
   input wire logic tag_pin_short_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic [DATA_W-1:0] control_fault_status_o,
   input wire logic [DATA_W-1:0] test_load_event_status_o,
   input wire logic interrupt_request_pin_o,
   input wire logic interrupt_request_pin_oe_o
);
   // ****
   // status checks
   // ****
   wire logic [DATA_W-1:0] cs = control_fault_status_o;
   wire logic [DATA_W-1:0] ts = test_load_event_status_o;
   wire logic w_pec = ce_i && req_i.wr && req_i.addr == 8'h22 && req_i.wdata[0];
   wire logic w_done = ce_i && req_i.wr && req_i.addr == 8'h23 && req_i.wdata[1];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_crc;
      ctrl_ev_i.crc_fail && enable_i.checksum_irq_enable ##1 enable_i.checksum_irq_enable |-> ##1 cs[4];
   endproperty
   a_crc: assert property (p_crc) else $error("checksum flag not set");
   property p_cdis;
      !enable_i.checksum_irq_enable |-> ##2 !cs[4];
   endproperty
   a_cdis: assert property (p_cdis) else $error("checksum flag set while off");
   property p_tmp;
      ctrl_ev_i.overtemp && enable_i.overtemperature_irq_enable ##1 enable_i.overtemperature_irq_enable |-> ##1 cs[2];
   endproperty
   a_tmp: assert property (p_tmp) else $error("thermal flag not set");
   property p_pin;
      irq_pin_short_i [*8] |-> cs[3];
   endproperty
   a_pin: assert property (p_pin) else $error("pin short flag missing");
   property p_pec;
      cs[0] && !w_pec && !$past(w_pec) |-> ##2 cs[0];
   endproperty
   a_pec: assert property (p_pec) else $error("packet flag lost");
   property p_ded;
      test_ev_i.double_err |-> ##2 ts[2];
   endproperty
   a_ded: assert property (p_ded) else $error("double error flag not set");
   property p_done;
      w_done && !test_ev_i.selftest_done |-> ##2 !ts[1];
   endproperty
   a_done: assert property (p_done) else $error("done flag not cleared");
   property p_irq;
      !interrupt_request_pin_o && interrupt_request_pin_oe_o == (|cs || |ts);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt pin wrong");
   property p_rdat;
      ce_i && req_i.rd && req_i.addr == 8'h22 |=> rvalid_o && rdata_o == cs;
   endproperty
   a_rdat: assert property (p_rdat) else $error("read data wrong");
   c_pec: cover property (w_pec && cs[0]);
   c_pin: cover property (cs[3] && irq_pin_short_i);
   c_irq: cover property (ts[0] && interrupt_request_pin_oe_o);
endmodule
`default_nettype wire

// file: testbench/cfs_host.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_host
   import cfs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rvalid_i,
   input wire logic [7:0] rdata_i,
   output var cfs_req_s req_o
);
   // ****
   // host bus cycles
   // ****
   initial req_o = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_i);
      req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // idle lines show junk so stale values never look valid
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      @(posedge clk_i);
      d = rvalid_i ? rdata_i : 8'hXX;
   endtask
endmodule
`default_nettype wire

// file: testbench/cfs_status_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_status_bank_bench
   import cfs_pkg::*;
;
   // ****
   // bench
   // ****
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ce_i = 1'b1;
   wire cfs_req_s req;
   cfs_ctrl_ev_s cev = '0;
   cfs_test_ev_s tev = '0;
   cfs_enable_s en = '1;
   logic ips = 1'b0;
   logic tps = 1'b0;
   logic [7:0] rdata, cs, ts;
   logic rvalid, irq, oe;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   cfs_status_bank DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .req_i(req), .ctrl_ev_i(cev),
      .test_ev_i(tev), .enable_i(en), .irq_pin_short_i(ips), .tag_pin_short_i(tps), .rdata_o(rdata),
      .rvalid_o(rvalid), .control_fault_status_o(cs), .test_load_event_status_o(ts),
      .interrupt_request_pin_o(irq), .interrupt_request_pin_oe_o(oe));
   cfs_host host (.clk_i(clk_i), .rvalid_i(rvalid), .rdata_i(rdata), .req_o(req));
   initial forever #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         conclude();
      end
   end
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      chk(d, exp);
   endtask
   task pulse(input logic [4:0] c, input logic [3:0] t);
      @(posedge clk_i);
      cev <= c;
      tev <= t;
      @(posedge clk_i);
      cev <= '0;
      tev <= '0;
   endtask
   task t_ev(input logic [7:0] a, input logic [7:0] m);
      pulse(a == 8'h22 ? m[4:0] : 5'h00, a == 8'h23 ? m[3:0] : 4'h0);
      rchk(a, m);
      chk({7'h00, oe}, 8'h01);
      chk(a == 8'h22 ? cs : ts, m);
      chk({7'h00, irq}, 8'h00);
      host.wr(a, 8'h00);
      rchk(a, m);
      host.wr(a, m);
      rchk(a, 8'h00);
      chk({7'h00, oe}, 8'h00);
      pulse(a == 8'h22 ? m[4:0] : 5'h00, a == 8'h23 ? m[3:0] : 4'h0);
      rchk(a, m);
      host.wr(a, m);
   endtask
   // enables off: only the ungated flags may appear
   task t_gate;
      @(posedge clk_i);
      en <= '0;
      tps <= 1'b1;
      pulse(5'h15, 4'hF);
      rchk(8'h23, 8'h04);
      // control read late enough for the synchronised tag short to be seen
      rchk(8'h22, 8'h01);
      chk(cs, 8'h01);
      host.wr(8'h22, 8'h01);
      host.wr(8'h23, 8'h04);
      tps <= 1'b0;
      // let the short leave the synchroniser before enabling again
      repeat (6) @(posedge clk_i);
      en <= '1;
   endtask
   // clock enable low: a clear must not land while frozen
   task t_ce;
      pulse(5'h00, 4'h2);
      @(posedge clk_i);
      ce_i <= 1'b0;
      host.wr(8'h23, 8'h02);
      @(posedge clk_i);
      ce_i <= 1'b1;
      rchk(8'h23, 8'h02);
      chk(ts, 8'h02);
      host.wr(8'h23, 8'h02);
      rchk(8'h23, 8'h00);
   endtask
   // level faults: clear refused while present, kept after removal
   task t_lvl;
      @(posedge clk_i);
      ips <= 1'b1;
      tps <= 1'b1;
      cev <= 5'h04;
      repeat (8) @(posedge clk_i);
      rchk(8'h22, 8'h0E);
      chk(cs, 8'h0E);
      host.wr(8'h22, 8'h0E);
      rchk(8'h22, 8'h0E);
      ips <= 1'b0;
      tps <= 1'b0;
      cev <= '0;
      repeat (8) @(posedge clk_i);
      rchk(8'h22, 8'h0E);
      host.wr(8'h22, 8'h0E);
      rchk(8'h22, 8'h00);
      chk({7'h00, oe}, 8'h00);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rchk(8'h22, 8'h00);
      rchk(8'h23, 8'h00);
      rchk(8'h24, 8'h00);
      t_ev(8'h22, 8'h10);
      t_ev(8'h22, 8'h01);
      t_ev(8'h23, 8'h08);
      t_ev(8'h23, 8'h04);
      t_ev(8'h23, 8'h02);
      t_ev(8'h23, 8'h01);
      t_gate();
      t_lvl();
      t_ce();
      conclude();
   end
endmodule
bind cfs_status_bank cfs_status_bank_props #(.DATA_W(DATA_W)) u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .ce_i(ce_i), .req_i(req_i), .ctrl_ev_i(ctrl_ev_i), .test_ev_i(test_ev_i), .enable_i(enable_i),
   .irq_pin_short_i(irq_pin_short_i), .tag_pin_short_i(tag_pin_short_i), .rdata_o(rdata_o),
   .rvalid_o(rvalid_o), .control_fault_status_o(control_fault_status_o),
   .test_load_event_status_o(test_load_event_status_o), .interrupt_request_pin_o(interrupt_request_pin_o),
   .interrupt_request_pin_oe_o(interrupt_request_pin_oe_o));
`default_nettype wire
